// >>> rtl/dmasei_pkg.sv
// Package: constants and carrier types of the DMA status, error and request block
package dmasei_pkg;
    localparam int NUM_CHAN = 8;
    localparam int CHAN_W = 3;
    localparam int BITS_PER_CHAN = 4;
    localparam int STATUS_W = 32;
    // Register block placement on the system bus
    localparam logic [31:0] BASE_ADDR = 32'hA000_0000;
    localparam logic [31:0] BASE_MASK = 32'hFFFF_F000;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h000;
    localparam logic [11:0] OFS_IRQ_FLAG_CLEAR = 12'h004;
    localparam logic [31:0] RST_IRQ_STATUS = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_FLAG_CLEAR = 32'h0000_0000;
    // Field positions inside each channel's nibble
    localparam int FLD_ANY = 0;
    localparam int FLD_DONE = 1;
    localparam int FLD_HALF = 2;
    localparam int FLD_ERR = 3;
    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [31:0] HRDATA_ZERO = 32'h0000_0000;
    // Reserved address window that faults a channel access
    localparam logic [31:0] RSV_LO = 32'h3000_0000;
    localparam logic [31:0] RSV_HI = 32'h3FFF_FFFF;

    typedef enum logic [1:0] {
        DMASEI_BUS_IDLE = 2'h0,
        DMASEI_BUS_ERR1 = 2'h1,
        DMASEI_BUS_ERR2 = 2'h3
    } dmasei_bus_t;

    // Channel access reported by the transfer engine
    typedef struct packed {
        logic valid;
        logic [CHAN_W-1:0] chan;
        logic [31:0] addr;
    } dmasei_acc_t;

    // Per-channel event pulses from the transfer engine
    typedef struct packed {
        logic [NUM_CHAN-1:0] done;
        logic [NUM_CHAN-1:0] half;
        logic [NUM_CHAN-1:0] err;
    } dmasei_evt_t;

    // Per-channel interrupt enables from the channel configuration
    typedef struct packed {
        logic [NUM_CHAN-1:0] done;
        logic [NUM_CHAN-1:0] half;
        logic [NUM_CHAN-1:0] err;
    } dmasei_ien_t;
endpackage : dmasei_pkg

// >>> rtl/dmasei_req_sel.sv
// Per-channel selection between peripheral request and converter request
`timescale 1ns/1ps
`default_nettype none
module dmasei_req_sel #(
    parameter int NCH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Requests and selection
    input wire logic [NCH-1:0] periphReq,
    input wire logic adcReq,
    input wire logic [NCH-1:0] selAdc,
    input wire logic [NCH-1:0] chanEnable,
    // Selected requests
    output logic [NCH-1:0] chanReq
);
    typedef struct packed {
        logic [NCH-1:0] req;
    } dmasei_sel_state_t;

    dmasei_sel_state_t state;
    dmasei_sel_state_t next_state;

    always_comb begin
        next_state = state;
        for (int i = 0; i < NCH; i++) begin
            next_state.req[i] = chanEnable[i] & (selAdc[i] ? adcReq : periphReq[i]);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign chanReq = state.req;

    property p_sel_route;
        @(posedge clock) disable iff (!rst_n)
        (chanEnable[0] && selAdc[0]) |=> (chanReq[0] == $past(adcReq));
    endproperty
    a_sel_route: assert property (p_sel_route) else $error("channel 0 did not follow converter request");
endmodule : dmasei_req_sel
`default_nettype wire

// >>> rtl/dmasei_buf2.sv
// Two-entry skid buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dmasei_buf2 #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Filling side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Draining side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    typedef struct packed {
        logic [WIDTH-1:0] head;
        logic headValid;
        logic [WIDTH-1:0] spare;
        logic spareValid;
        logic ready;
    } dmasei_buf_state_t;

    dmasei_buf_state_t state;
    dmasei_buf_state_t next_state;
    logic accept;
    logic pop;

    assign accept = inValid & state.ready;
    assign pop = state.headValid & outReady;

    // Ready is registered, so the spare slot catches the word taken while the drain stalls
    always_comb begin
        next_state = state;
        if (pop) begin
            if (state.spareValid) begin
                next_state.head = state.spare;
                next_state.spareValid = 1'b0;
            end else begin
                next_state.headValid = accept;
                next_state.head = inData;
            end
        end else if (accept) begin
            if (!state.headValid) begin
                next_state.head = inData;
                next_state.headValid = 1'b1;
            end else begin
                next_state.spare = inData;
                next_state.spareValid = 1'b1;
            end
        end
        next_state.ready = !next_state.spareValid;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign inReady = state.ready;
    assign outValid = state.headValid;
    assign outData = state.head;
endmodule : dmasei_buf2
`default_nettype wire

// >>> rtl/dmasei_top.sv
// DMA status, error, interrupt and request selection block with its bus registers
// Notes on behaviour
// - Access to reserved space flags error
// - Error clears the channel enable bit
// - Error sets flag; interrupt only if enabled
// - Half, done, error each separately enabled
// - Eight peripheral requests muxed with converter
// - Per-channel field selects request source
// - Registers decoded at base 0xA0000000
// - Status at 0x00, read-only, resets zero
// - Flag clear at 0x04, write-only, zero
// - Four status bits per channel
// - Any-event flag shows any channel event
// - Hardware sets; software writes one clears
// - Flags reset zero, set by event
// - Only word accesses; others bus fault
// - Same layout continues for higher channels
`timescale 1ns/1ps
`default_nettype none
module dmasei_top #(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // System bus slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Transfer engine reports
    input wire dmasei_pkg::dmasei_acc_t acc,
    input wire dmasei_pkg::dmasei_evt_t evt,
    // Channel configuration
    input wire dmasei_pkg::dmasei_ien_t irqEn,
    input wire logic cfgEnableWrite,
    input wire logic [dmasei_pkg::NUM_CHAN-1:0] cfgEnable,
    input wire logic [dmasei_pkg::NUM_CHAN-1:0] reqSelAdc,
    output logic [dmasei_pkg::NUM_CHAN-1:0] chanEnable,
    // Requests
    input wire logic [dmasei_pkg::NUM_CHAN-1:0] periphReq,
    input wire logic adcReq,
    output logic [dmasei_pkg::NUM_CHAN-1:0] chanReq,
    // Data path
    input wire logic rdValid,
    input wire logic [DATA_W-1:0] rdData,
    output logic rdReady,
    output logic wrValid,
    output logic [DATA_W-1:0] wrData,
    input wire logic wrReady,
    // Interrupt
    output logic irq
);
    localparam int NCH = dmasei_pkg::NUM_CHAN;

    typedef struct packed {
        logic [dmasei_pkg::STATUS_W-1:0] flags;
        logic [NCH-1:0] enable;
        logic irq;
        logic [31:0] rdata;
        logic readyOut;
        logic resp;
        dmasei_pkg::dmasei_bus_t bst;
        logic wrPend;
    } dmasei_state_t;

    dmasei_state_t state;
    dmasei_state_t next_state;

    logic [NCH-1:0] errHit;
    logic [NCH-1:0] evAny;
    logic [dmasei_pkg::STATUS_W-1:0] setMask;
    logic [dmasei_pkg::STATUS_W-1:0] clrMask;
    logic [NCH-1:0] anyFlags;
    logic [NCH-1:0] doneFlags;
    logic [NCH-1:0] halfFlags;
    logic [NCH-1:0] errFlags;
    logic addrPhase;
    logic sizeOk;
    logic [11:0] ofs;

    function automatic logic is_reserved(input logic [31:0] a);
        is_reserved = (a >= dmasei_pkg::RSV_LO) && (a <= dmasei_pkg::RSV_HI);
    endfunction : is_reserved

    function automatic int fld_pos(input int ch, input int fld);
        fld_pos = ch * dmasei_pkg::BITS_PER_CHAN + fld;
    endfunction : fld_pos

    assign addrPhase = hsel && hready && htrans[1]
        && ((haddr & dmasei_pkg::BASE_MASK) == dmasei_pkg::BASE_ADDR);
    assign sizeOk = (hsize == dmasei_pkg::HSIZE_WORD);
    assign ofs = haddr[11:0];

    assign clrMask = state.wrPend ? hwdata : dmasei_pkg::RST_IRQ_FLAG_CLEAR;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            assign errHit[g] = evt.err[g]
                || (acc.valid && (int'(acc.chan) == g) && is_reserved(acc.addr));
            assign evAny[g] = errHit[g] | evt.half[g] | evt.done[g];
            assign setMask[fld_pos(g, dmasei_pkg::FLD_ANY)] = evAny[g];
            assign setMask[fld_pos(g, dmasei_pkg::FLD_DONE)] = evt.done[g];
            assign setMask[fld_pos(g, dmasei_pkg::FLD_HALF)] = evt.half[g];
            assign setMask[fld_pos(g, dmasei_pkg::FLD_ERR)] = errHit[g];
            assign anyFlags[g] = state.flags[fld_pos(g, dmasei_pkg::FLD_ANY)];
            assign doneFlags[g] = state.flags[fld_pos(g, dmasei_pkg::FLD_DONE)];
            assign halfFlags[g] = state.flags[fld_pos(g, dmasei_pkg::FLD_HALF)];
            assign errFlags[g] = state.flags[fld_pos(g, dmasei_pkg::FLD_ERR)];
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.flags = (state.flags & ~clrMask) | setMask;
        if (cfgEnableWrite) begin
            next_state.enable = cfgEnable;
        end
        next_state.enable = next_state.enable & ~errHit;
        next_state.irq = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if ((next_state.flags[fld_pos(i, dmasei_pkg::FLD_DONE)] && irqEn.done[i])
                || (next_state.flags[fld_pos(i, dmasei_pkg::FLD_HALF)] && irqEn.half[i])
                || (next_state.flags[fld_pos(i, dmasei_pkg::FLD_ERR)] && irqEn.err[i])) begin
                next_state.irq = 1'b1;
            end
        end
        next_state.wrPend = 1'b0;
        next_state.rdata = dmasei_pkg::HRDATA_ZERO;
        case (state.bst)
            dmasei_pkg::DMASEI_BUS_ERR1: begin
                next_state.bst = dmasei_pkg::DMASEI_BUS_ERR2;
                next_state.readyOut = 1'b1;
                next_state.resp = 1'b1;
            end
            dmasei_pkg::DMASEI_BUS_ERR2: begin
                next_state.bst = dmasei_pkg::DMASEI_BUS_IDLE;
                next_state.readyOut = 1'b1;
                next_state.resp = 1'b0;
            end
            default: begin
                next_state.bst = dmasei_pkg::DMASEI_BUS_IDLE;
                next_state.readyOut = 1'b1;
                next_state.resp = 1'b0;
                if (addrPhase && !sizeOk) begin
                    next_state.bst = dmasei_pkg::DMASEI_BUS_ERR1;
                    next_state.readyOut = 1'b0;
                    next_state.resp = 1'b1;
                end else if (addrPhase && hwrite) begin
                    next_state.wrPend = (ofs == dmasei_pkg::OFS_IRQ_FLAG_CLEAR);
                end else if (addrPhase && (ofs == dmasei_pkg::OFS_IRQ_STATUS)) begin
                    next_state.rdata = state.flags;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{flags: dmasei_pkg::RST_IRQ_STATUS, enable: '0, irq: 1'b0, rdata: dmasei_pkg::HRDATA_ZERO,
                       readyOut: 1'b1, resp: 1'b0, bst: dmasei_pkg::DMASEI_BUS_IDLE, wrPend: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign hrdata = state.rdata;
    assign hreadyout = state.readyOut;
    assign hresp = state.resp;
    assign irq = state.irq;
    assign chanEnable = state.enable;

    dmasei_req_sel #(.NCH(NCH)) u_req_sel (
        .clock(clock),
        .rst_n(rst_n),
        .periphReq(periphReq),
        .adcReq(adcReq),
        .selAdc(reqSelAdc),
        .chanEnable(state.enable),
        .chanReq(chanReq)
    );

    // Absorbs one word of receiver stall without dropping the read
    dmasei_buf2 #(.WIDTH(DATA_W)) u_buf (
        .clock(clock),
        .rst_n(rst_n),
        .inValid(rdValid),
        .inData(rdData),
        .inReady(rdReady),
        .outValid(wrValid),
        .outData(wrData),
        .outReady(wrReady)
    );

    property p_rsv_error;
        @(posedge clock) disable iff (!rst_n)
        (acc.valid && is_reserved(acc.addr)) |=> errFlags[$past(acc.chan)];
    endproperty
    a_rsv_error: assert property (p_rsv_error) else $error("reserved access did not flag error");

    property p_err_disable;
        @(posedge clock) disable iff (!rst_n)
        (|errHit) |=> ((chanEnable & $past(errHit)) == '0);
    endproperty
    a_err_disable: assert property (p_err_disable) else $error("faulty channel still enabled");

    property p_err_flag;
        @(posedge clock) disable iff (!rst_n)
        (|errHit) |=> ((errFlags & $past(errHit)) == $past(errHit));
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag not set");

    property p_any_flag;
        @(posedge clock) disable iff (!rst_n)
        (|evAny) |=> ((anyFlags & $past(evAny)) == $past(evAny));
    endproperty
    a_any_flag: assert property (p_any_flag) else $error("any-event flag not set");

    property p_clear;
        @(posedge clock) disable iff (!rst_n)
        (state.wrPend && (setMask == '0)) |=> ((state.flags & $past(hwdata)) == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("flag survived a clear");

    property p_keep;
        @(posedge clock) disable iff (!rst_n)
        (setMask == '0) |=> ((state.flags & ~$past(clrMask)) == ($past(state.flags) & ~$past(clrMask)));
    endproperty
    a_keep: assert property (p_keep) else $error("flag changed without a clear");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        ##1 (irq == |((doneFlags & $past(irqEn.done)) | (halfFlags & $past(irqEn.half))
            | (errFlags & $past(irqEn.err))));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt disagrees with enabled flags");

    property p_size_fault;
        @(posedge clock) disable iff (!rst_n)
        (addrPhase && !sizeOk && (state.bst == dmasei_pkg::DMASEI_BUS_IDLE))
            |=> (!hreadyout && hresp) ##1 (hreadyout && hresp) ##1 !hresp;
    endproperty
    a_size_fault: assert property (p_size_fault) else $error("narrow access not faulted");

    property p_read_status;
        @(posedge clock) disable iff (!rst_n)
        (addrPhase && sizeOk && !hwrite && (ofs == dmasei_pkg::OFS_IRQ_STATUS)
            && (state.bst == dmasei_pkg::DMASEI_BUS_IDLE)) |=> (hrdata == $past(state.flags));
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read returned wrong value");

    property p_half_flag;
        @(posedge clock) disable iff (!rst_n)
        (|evt.half) |=> ((halfFlags & $past(evt.half)) == $past(evt.half));
    endproperty
    a_half_flag: assert property (p_half_flag) else $error("half transfer flag not set");

    property p_done_flag;
        @(posedge clock) disable iff (!rst_n)
        (|evt.done) |=> ((doneFlags & $past(evt.done)) == $past(evt.done));
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("completion flag not set");

    property p_clear_reads_zero;
        @(posedge clock) disable iff (!rst_n)
        (addrPhase && sizeOk && !hwrite && (ofs == dmasei_pkg::OFS_IRQ_FLAG_CLEAR)
            && (state.bst == dmasei_pkg::DMASEI_BUS_IDLE)) |=> (hrdata == dmasei_pkg::HRDATA_ZERO);
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read not zero");

    property p_word_okay;
        @(posedge clock) disable iff (!rst_n)
        (addrPhase && sizeOk && (state.bst == dmasei_pkg::DMASEI_BUS_IDLE)) |=> (hreadyout && !hresp);
    endproperty
    a_word_okay: assert property (p_word_okay) else $error("word access not answered okay");

    property p_irq_needs_enable;
        @(posedge clock) disable iff (!rst_n)
        (irqEn == '0) |=> !irq;
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("interrupt raised with no enable");
endmodule : dmasei_top
`default_nettype wire

// >>> tb/dmasei_stream_partner.sv
// Far-side stream model: word source for the fill side, stalling sink for the drain side
`timescale 1ns/1ps
`default_nettype none
module dmasei_stream_partner (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Bench controls
    input wire logic sendEn,
    input wire logic slowSink,
    // Fill side of the block
    input wire logic rdReady,
    output logic rdValid,
    output logic [31:0] rdData,
    // Drain side of the block
    input wire logic wrValid,
    input wire logic [31:0] wrData,
    output logic wrReady,
    // Results
    output int rxCount,
    output int errCount
);
    logic [31:0] txWord;
    logic [1:0] phase;

    // A slow sink accepts one cycle in four
    assign wrReady = !slowSink || (phase == 2'h3);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdValid <= 1'b0;
            txWord <= 32'h0000_1000;
            rdData <= 32'hFFFF_EFFF;
            phase <= 2'h0;
            rxCount <= 0;
            errCount <= 0;
        end else begin
            phase <= phase + 2'h1;
            // A word is held until taken; idle data is the inverse of the last word
            if (rdValid && rdReady) begin
                txWord <= txWord + 32'h1;
                rdValid <= sendEn;
                rdData <= sendEn ? txWord + 32'h1 : ~txWord;
            end else if (!rdValid && sendEn) begin
                rdValid <= 1'b1;
                rdData <= txWord;
            end
            // Words must arrive in order, none lost or repeated
            if (wrValid && wrReady) begin
                rxCount <= rxCount + 1;
                if (wrData !== 32'h0000_1000 + 32'(rxCount)) begin
                    errCount <= errCount + 1;
                end
            end
        end
    end
endmodule : dmasei_stream_partner
`default_nettype wire

// >>> tb/dmasei_bench.sv
// Self-checking bench for the DMA status, error and request block
`timescale 1ns/1ps
`default_nettype none
module dmasei_bench;
    localparam logic [31:0] B = dmasei_pkg::BASE_ADDR;
    logic clock, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq, rsp, rdy;
    logic cfgEnableWrite, adcReq, rdValid, rdReady, wrValid, wrReady, sendEn, slowSink;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdData, wrData, rd;
    logic [7:0] cfgEnable, reqSelAdc, chanEnable, periphReq, chanReq;
    dmasei_pkg::dmasei_acc_t acc;
    dmasei_pkg::dmasei_evt_t evt;
    dmasei_pkg::dmasei_ien_t irqEn;
    int n_fail, n_compared, rxCount, errCount;

    dmasei_top dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .acc, .evt, .irqEn, .cfgEnableWrite, .cfgEnable, .reqSelAdc, .chanEnable,
        .periphReq, .adcReq, .chanReq, .rdValid, .rdData, .rdReady, .wrValid, .wrData, .wrReady, .irq);
    dmasei_stream_partner far (.clock, .rst_n, .sendEn, .slowSink, .rdReady, .rdValid, .rdData,
        .wrValid, .wrData, .wrReady, .rxCount, .errCount);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task report_and_stop;
        $display("Counts: %0d compared, %0d mismatched", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // One AHB-lite transfer; rd, rsp and rdy hold the data-phase answer
    task bus(input logic w, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(negedge clock);
        rd = hrdata;
        rsp = hresp;
        rdy = hreadyout;
        // Lets an error response finish and a clear land
        repeat (2) @(posedge clock);
    endtask : bus

    task pulse(input dmasei_pkg::dmasei_evt_t e, input dmasei_pkg::dmasei_acc_t a);
        @(posedge clock);
        evt <= e;
        acc <= a;
        @(posedge clock);
        evt <= '0;
        acc <= '0;
    endtask : pulse

    task cfg(input logic [7:0] m);
        @(posedge clock);
        cfgEnable <= m;
        cfgEnableWrite <= 1'b1;
        @(posedge clock);
        cfgEnableWrite <= 1'b0;
    endtask : cfg

    task t_reset;
        bus(1'b0, B, 3'h2, 32'h0);
        chk(rd, dmasei_pkg::RST_IRQ_STATUS, "status reset");
        chk(32'(rsp), 32'h0, "okay resp");
        chk(32'(rdy), 32'h1, "okay no wait");
        chk(32'(chanEnable), 32'h0, "enables reset");
        chk(32'(irq), 32'h0, "irq reset");
        $display("test reset done");
    endtask : t_reset

    task t_events;
        logic [31:0] v;
        cfg(8'hFF);
        for (int ch = 0; ch < 8; ch++) begin
            for (int k = 0; k < 3; k++) begin
                v = 32'h1 << (ch + 8 * (2 - k));
                irqEn <= (ch % 2 == 0) ? v[23:0] : 24'h0;
                pulse(v[23:0], '0);
                bus(1'b0, B, 3'h2, 32'h0);
                chk(rd, (32'h1 | (32'h1 << (k + 1))) << (4 * ch), "flag set");
                chk(32'(irq), 32'(ch % 2 == 0), "irq gating");
                bus(1'b1, B + 32'h4, 3'h2, 32'hFFFF_FFFF);
                bus(1'b0, B, 3'h2, 32'h0);
                chk(rd, 32'h0, "flags cleared");
                chk(32'(irq), 32'h0, "irq drops");
            end
        end
        chk(32'(chanEnable), 32'h0, "error disables");
        $display("test events done");
    endtask : t_events

    task t_refuse;
        pulse(24'h02_0400, '0);
        bus(1'b1, B + 32'h4, 3'h2, 32'h0000_0020);
        bus(1'b0, B, 3'h2, 32'h0);
        chk(rd, 32'h0000_0510, "partial clear");
        for (int sz = 0; sz < 2; sz++) begin
            bus(1'b1, B + 32'h4, 3'(sz), 32'hFFFF_FFFF);
            chk(32'(rsp), 32'h1, "narrow fault");
            chk(32'(rdy), 32'h0, "fault wait state");
        end
        bus(1'b1, B, 3'h2, 32'hFFFF_FFFF);
        bus(1'b0, B, 3'h2, 32'h0);
        chk(rd, 32'h0000_0510, "status read-only");
        bus(1'b0, B + 32'h4, 3'h2, 32'h0);
        chk(rd, 32'h0, "clear reads zero");
        bus(1'b0, B + 32'h1000, 3'h2, 32'h0);
        chk({rd[31:1], rsp}, 32'h0, "outside base");
        bus(1'b1, B + 32'h4, 3'h2, 32'hFFFF_FFFF);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_reserved;
        logic [31:0] ad[4] = '{32'h2FFF_FFFC, 32'h3000_0000, 32'h3FFF_FFFC, 32'h4000_0000};
        logic hit;
        cfg(8'hFF);
        irqEn <= 24'h00_00FF;
        for (int i = 0; i < 4; i++) begin
            hit = (i == 1 || i == 2);
            pulse('0, {1'b1, 3'(i + 4), ad[i]});
            bus(1'b0, B, 3'h2, 32'h0);
            chk(rd, hit ? 32'h9 << (4 * (i + 4)) : 32'h0, "reserved access");
            chk(32'(chanEnable[i + 4]), 32'(!hit), "channel stop");
            chk(32'(irq), 32'(hit), "error irq");
            bus(1'b1, B + 32'h4, 3'h2, 32'hFFFF_FFFF);
        end
        $display("test reserved done");
    endtask : t_reserved

    task automatic t_reqmux;
        logic [7:0] s[3] = '{8'h0F, 8'h0F, 8'hF0};
        logic [7:0] p[3] = '{8'hA5, 8'hA5, 8'h5A};
        logic [7:0] e[3] = '{8'h2F, 8'h20, 8'h7A};
        cfg(8'h7F);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            reqSelAdc <= s[i];
            periphReq <= p[i];
            adcReq <= (i != 1);
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk(32'(chanReq), 32'(e[i]), "request select");
        end
        $display("test reqmux done");
    endtask : t_reqmux

    task t_buffer;
        int sent;
        logic full;
        sent = 0;
        full = 1'b0;
        @(posedge clock);
        sendEn <= 1'b1;
        slowSink <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            if (i == 40) begin
                @(posedge clock);
                sendEn <= 1'b0;
                slowSink <= 1'b0;
            end
            @(negedge clock);
            if (rdValid && rdReady) sent++;
            if (rdReady === 1'b0) full = 1'b1;
        end
        chk(32'(full), 32'h1, "buffer refuses when full");
        chk(32'(rxCount), 32'(sent), "no word lost");
        chk(32'(errCount), 32'h0, "word order");
        chk(32'(wrValid), 32'h0, "buffer drained");
        $display("test buffer done");
    endtask : t_buffer

    initial begin
        {rst_n, hsel, hwrite, cfgEnableWrite, adcReq, sendEn, slowSink} = '0;
        hready = 1'b1;
        {htrans, hsize, haddr, hwdata} = '0;
        {cfgEnable, reqSelAdc, periphReq} = '0;
        {acc, evt, irqEn} = '0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_events();
        t_refuse();
        t_reserved();
        t_reqmux();
        t_buffer();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        report_and_stop();
    end
endmodule : dmasei_bench
`default_nettype wire
